// file: core/ddm_pkg.sv
// constants and types for the dual input deserializer mode and input mux
// assumes a single 125 MHz system clock domain
package ddm_pkg;
    // register offsets
    localparam logic [7:0] REG_PORT_CFG = 8'h6D;
    localparam logic [7:0] REG_SEL_CTRL = 8'h70;
    localparam logic [7:0] REG_STATUS   = 8'h71;
    // port_link_config fields
    localparam int CFG_MODE_LSB = 0;
    localparam int CFG_COAX_BIT = 2;
    // select control fields
    localparam int CTRL_OVR_BIT = 0;
    localparam int CTRL_SEL_BIT = 1;
    localparam int CTRL_BC_BIT  = 2;
    // status fields
    localparam int STS_PORT_BIT = 0;
    localparam int STS_PERR_BIT = 1;
    localparam int STS_SBAD_BIT = 2;
    localparam int STS_CODE_LSB = 4;
    // reset values
    localparam logic [7:0] CFG_RST  = 8'h00;
    localparam logic [7:0] CTRL_RST = 8'h04;
    // frame layout
    localparam int FRM_W       = 28;
    localparam int PAY_W       = 21;
    localparam int PIX_W       = 14;
    localparam int HALF_W      = 7;
    localparam int FRM_CTL_BIT = 24;
    localparam int FRM_PAR_BIT = 27;
    localparam int FIFO_DEPTH  = 8;
    // cycles after reset release before the strap is taken
    localparam logic [1:0] STRAP_CAPT_CYC = 2'h2;
    // strap code bit that selects coax
    localparam int STRAP_COAX_BIT = 2;

    typedef enum logic [1:0] {
        MODE_WIDE_LOW  = 2'h0,
        MODE_WIDE_HIGH = 2'h1,
        MODE_NARROW    = 2'h2,
        MODE_RSVD      = 2'h3
    } ddm_mode_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_PUSH = 2'b10
    } ddm_st_t;

    typedef struct packed {
        logic [1:0]  sync;
        logic [11:0] data;
    } ddm_pix_t;
endpackage

// file: core/ddm_mode_mux.sv
// input mux, mode control and pixel unpack of the dual input deserializer
// assumes link clocks and frames come from outside and are sampled here
//
// Contract
// [R1] each forward frame is 28 bits: payload, sync, control bit, parity
// [R2] wide high mode gives 12 data plus 2 sync bits per pixel
// [R3] narrow mode sender toggles sync at most once per ten pixels
// [R4] wide low mode gives 12 data plus 2 sync bits per pixel
// [R5] pixels per frame: one wide low, two narrow, three per two wide high
// [R6] one frame per link clock edge, line rate follows the mode
// [R7] exactly one of two inputs feeds the pixel output at a time
// [R8] active input chosen by select pin or by register
// [R9] reverse channel driver on only for the selected input
// [R10] controller selects new input first, then enables its reverse channel
// [R11] mode comes from strap, register bits 1:0 override it
// [R12] strap codes 1-3 twisted pair, 5-7 coax, 0 and 4 reserved
// [R13] cable type at bit 2 and mode at bits 1:0, read and write
// [R14] output 10 or 12 bits by mode, control sent back on the link
// [R15] control traffic runs at any time, independent of blanking
// [R16] control channel driven from the local control port
// [R17] strap taken after reset, register writes replace it until reset
`timescale 1ns/10ps
`default_nettype none

module ddm_fifo
    import ddm_pkg::*;
#(
    parameter int W = PIX_W,
    parameter int D = FIFO_DEPTH
)(
    // clock and reset
    input  wire logic         sys_clk_i,
    input  wire logic         rst_n_i,
    // fill side
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    // drain side
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_r [D];
    logic [AW:0]  wp_r;
    logic [AW:0]  wp_nxt;
    logic [AW:0]  rp_r;
    logic [AW:0]  rp_nxt;
    logic         push;
    logic         pop;

    assign in_ready_o  = !((wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]));
    assign out_valid_o = (wp_r != rp_r);
    assign out_data_o  = mem_r[rp_r[AW-1:0]];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_comb
    begin
        wp_nxt = push ? wp_r + 1'b1 : wp_r;
        rp_nxt = pop ? rp_r + 1'b1 : rp_r;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            wp_r <= '0;
            rp_r <= '0;
        end
        else
        begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
        end
        if (push)
            mem_r[wp_r[AW-1:0]] <= in_data_i;
    end
endmodule

module ddm_mode_mux
    import ddm_pkg::*;
(
    // clock and reset
    input  wire logic                 sys_clk_i,
    input  wire logic                 rst_n_i,
    // serial links, already deserialized per frame
    input  wire logic [1:0]           lnk_clk_i,
    input  wire logic [1:0][FRM_W-1:0] lnk_frame_i,
    // pins
    input  wire logic                 sel_pin_i,
    input  wire logic [2:0]           strap_code_i,
    // local control port
    input  wire logic                 reg_wr_i,
    input  wire logic [7:0]           reg_addr_i,
    input  wire logic [7:0]           reg_wdata_i,
    output logic [7:0]                reg_rdata_o,
    input  wire logic                 ctl_tx_i,
    output logic                      ctl_rx_o,
    // reverse channel drivers
    output logic [1:0]                bc_en_o,
    output logic [1:0]                bc_data_o,
    // pixel output
    output ddm_pix_t                  pix_o,
    output logic                      pix_valid_o,
    input  wire logic                 pix_ready_i,
    output logic                      pclk_o
);
    // pin synchronisers
    logic [1:0]            lclk_s1_r;
    logic [1:0]            lclk_s2_r;
    logic [1:0]            lclk_d_r;
    logic [1:0][FRM_W-1:0] frm_s1_r;
    logic [1:0][FRM_W-1:0] frm_s2_r;
    logic [1:0]            sel_s_r;
    logic [2:0]            strap_s1_r;
    logic [2:0]            strap_s2_r;

    always_ff @(posedge sys_clk_i)
    begin
        lclk_s1_r  <= lnk_clk_i;
        lclk_s2_r  <= lclk_s1_r;
        lclk_d_r   <= lclk_s2_r;
        frm_s1_r   <= lnk_frame_i;
        frm_s2_r   <= frm_s1_r;
        sel_s_r    <= {sel_s_r[0], sel_pin_i};
        strap_s1_r <= strap_code_i;
        strap_s2_r <= strap_s1_r;
    end

    // control state
    logic [1:0] cnt_r, cnt_nxt;
    logic [1:0] mode_r, mode_nxt;
    logic       coax_r, coax_nxt;
    logic [2:0] ctrl_r, ctrl_nxt;
    logic       act_r, act_nxt;
    logic       perr_r, perr_nxt;
    logic       sbad_r, sbad_nxt;
    logic [2:0] code_r, code_nxt;
    logic [7:0] rdata_nxt;
    logic       ctl_rx_nxt;
    logic       wr_cfg;
    logic       wr_ctrl;
    logic [1:0] strap_mode;
    logic       frm_evt;
    logic [FRM_W-1:0] frm;

    assign wr_cfg  = reg_wr_i && (reg_addr_i == REG_PORT_CFG);
    assign wr_ctrl = reg_wr_i && (reg_addr_i == REG_SEL_CTRL);
    // [R6] [R7] one frame per active link edge
    assign frm_evt = lclk_s2_r[act_r] && !lclk_d_r[act_r];
    assign frm     = frm_s2_r[act_r];

    always_comb
    begin
        // [R12] strap decode
        case (strap_s2_r[1:0])
            2'h1:    strap_mode = MODE_WIDE_LOW;
            2'h2:    strap_mode = MODE_WIDE_HIGH;
            2'h3:    strap_mode = MODE_NARROW;
            default: strap_mode = MODE_WIDE_LOW;
        endcase
        cnt_nxt    = (cnt_r == STRAP_CAPT_CYC) ? cnt_r : cnt_r + 2'h1;
        mode_nxt   = mode_r;
        coax_nxt   = coax_r;
        sbad_nxt   = sbad_r;
        code_nxt   = code_r;
        // [R17] strap taken once after release
        if (cnt_r == STRAP_CAPT_CYC - 2'h1)
        begin
            mode_nxt = strap_mode;
            coax_nxt = strap_s2_r[STRAP_COAX_BIT];
            sbad_nxt = (strap_s2_r[1:0] == 2'h0);
            code_nxt = strap_s2_r;
        end
        // [R11] register override of mode and cable
        if (wr_cfg)
        begin
            mode_nxt = reg_wdata_i[CFG_MODE_LSB +: 2];
            coax_nxt = reg_wdata_i[CFG_COAX_BIT];
        end
        ctrl_nxt = wr_ctrl ? reg_wdata_i[2:0] : ctrl_r;
        // [R8] pin or register select
        act_nxt = ctrl_r[CTRL_OVR_BIT] ? ctrl_r[CTRL_SEL_BIT] : sel_s_r[1];
        // [R1] even parity over the frame, sticky until status write
        perr_nxt = perr_r;
        if (reg_wr_i && (reg_addr_i == REG_STATUS))
            perr_nxt = 1'b0;
        if (frm_evt && ^frm)
            perr_nxt = 1'b1;
        // [R15] control bit forwarded on every frame
        ctl_rx_nxt = frm_evt ? frm[FRM_CTL_BIT] : ctl_rx_o;
        // [R13] readback of strapped or written values
        case (reg_addr_i)
            REG_PORT_CFG: rdata_nxt = {5'h00, coax_r, mode_r};
            REG_SEL_CTRL: rdata_nxt = {5'h00, ctrl_r};
            REG_STATUS:   rdata_nxt = {1'b0, code_r, 1'b0, sbad_r, perr_r, act_r};
            default:      rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            cnt_r       <= 2'h0;
            mode_r      <= CFG_RST[1:0];
            coax_r      <= CFG_RST[CFG_COAX_BIT];
            ctrl_r      <= CTRL_RST[2:0];
            act_r       <= 1'b0;
            perr_r      <= 1'b0;
            sbad_r      <= 1'b0;
            code_r      <= 3'h0;
            reg_rdata_o <= 8'h00;
            ctl_rx_o    <= 1'b0;
        end
        else
        begin
            cnt_r       <= cnt_nxt;
            mode_r      <= mode_nxt;
            coax_r      <= coax_nxt;
            ctrl_r      <= ctrl_nxt;
            act_r       <= act_nxt;
            perr_r      <= perr_nxt;
            sbad_r      <= sbad_nxt;
            code_r      <= code_nxt;
            reg_rdata_o <= rdata_nxt;
            ctl_rx_o    <= ctl_rx_nxt;
        end
    end

    // reverse channel, per port
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_bc
            // [R9] driver follows active port, [R10] enabled by register after select
            assign bc_en_o[gi]   = ctrl_r[CTRL_BC_BIT] && (act_r == 1'(gi));
            // [R16] local control bit sent back
            assign bc_data_o[gi] = bc_en_o[gi] && ctl_tx_i;
        end
    endgenerate

    // pixel unpack
    ddm_st_t          st_r, st_nxt;
    ddm_pix_t [2:0]   stg_r, stg_nxt;
    logic [1:0]       stg_cnt_r, stg_cnt_nxt;
    logic [1:0]       stg_idx_r, stg_idx_nxt;
    logic             ph_r, ph_nxt;
    logic [HALF_W-1:0] carry_r, carry_nxt;
    logic             f_ready;
    logic             f_valid;
    ddm_pix_t         f_data;

    assign f_valid = (st_r == ST_PUSH);
    assign f_data  = stg_r[stg_idx_r];

    always_comb
    begin
        st_nxt      = st_r;
        stg_nxt     = stg_r;
        stg_cnt_nxt = stg_cnt_r;
        stg_idx_nxt = stg_idx_r;
        ph_nxt      = ph_r;
        carry_nxt   = carry_r;
        case (st_r)
            ST_IDLE:
            begin
                if (frm_evt)
                begin
                    stg_idx_nxt = 2'h0;
                    st_nxt      = ST_PUSH;
                    // [R5] pixels per frame by mode
                    case (mode_r)
                        MODE_NARROW:
                        begin
                            // [R14] 10 data bits, upper two zero
                            stg_nxt[0]  = {frm[11:10], 2'h0, frm[9:0]};
                            stg_nxt[1]  = {frm[23:22], 2'h0, frm[21:12]};
                            stg_cnt_nxt = 2'h2;
                        end
                        MODE_WIDE_HIGH:
                        begin
                            // [R2] three 14-bit pixels over two frames
                            if (!ph_r)
                            begin
                                stg_nxt[0]  = frm[PIX_W-1:0];
                                carry_nxt   = frm[PAY_W-1:PIX_W];
                                stg_cnt_nxt = 2'h1;
                            end
                            else
                            begin
                                stg_nxt[0]  = {frm[HALF_W-1:0], carry_r};
                                stg_nxt[1]  = frm[PAY_W-1:HALF_W];
                                stg_cnt_nxt = 2'h2;
                            end
                            ph_nxt = !ph_r;
                        end
                        default:
                        begin
                            // [R4] one 14-bit pixel per frame
                            stg_nxt[0]  = frm[PIX_W-1:0];
                            stg_cnt_nxt = 2'h1;
                        end
                    endcase
                end
            end
            ST_PUSH:
            begin
                if (f_ready)
                begin
                    stg_idx_nxt = stg_idx_r + 2'h1;
                    if (stg_idx_r + 2'h1 == stg_cnt_r)
                        st_nxt = ST_IDLE;
                end
            end
            default:
                st_nxt = ST_IDLE;
        endcase
        if (mode_r != MODE_WIDE_HIGH)
            ph_nxt = 1'b0;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            st_r      <= ST_IDLE;
            stg_r     <= '0;
            stg_cnt_r <= 2'h0;
            stg_idx_r <= 2'h0;
            ph_r      <= 1'b0;
            carry_r   <= '0;
            pclk_o    <= 1'b0;
        end
        else
        begin
            st_r      <= st_nxt;
            stg_r     <= stg_nxt;
            stg_cnt_r <= stg_cnt_nxt;
            stg_idx_r <= stg_idx_nxt;
            ph_r      <= ph_nxt;
            carry_r   <= carry_nxt;
            pclk_o    <= pix_valid_o && pix_ready_i;
        end
    end

    ddm_fifo #(.W(PIX_W), .D(FIFO_DEPTH)) u_fifo (
        .sys_clk_i   (sys_clk_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (f_valid),
        .in_ready_o  (f_ready),
        .in_data_i   (f_data),
        .out_valid_o (pix_valid_o),
        .out_ready_i (pix_ready_i),
        .out_data_o  (pix_o)
    );

    // checks
    AST_ONE_BC: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        $onehot0(bc_en_o)) else $error("two reverse drivers on"); // [R9]
    AST_BC_SEL: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (bc_en_o != 2'h0) |-> bc_en_o[act_r]) else $error("driver on idle port"); // [R9]
    AST_SEL_PIN: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        !ctrl_r[CTRL_OVR_BIT] && !wr_ctrl ##1 !ctrl_r[CTRL_OVR_BIT] |->
        act_r == $past(sel_s_r[1])) else $error("select pin not followed"); // [R8]
    AST_WR_MODE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        wr_cfg |=> mode_r == $past(reg_wdata_i[1:0])) else $error("mode write lost"); // [R11]
    AST_WR_COAX: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        wr_cfg ##1 1'b1 ##1 1'b1 |-> reg_rdata_o[CFG_COAX_BIT] == $past(reg_wdata_i[2], 2)
        || $past(reg_addr_i) != REG_PORT_CFG) else $error("cable bit readback"); // [R13]
    AST_STRAP: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (cnt_r == 2'h1) && !wr_cfg |=> (mode_r == $past(strap_mode))
        && (coax_r == $past(strap_s2_r[2]))) else $error("strap not taken"); // [R12]
    AST_HOLD: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (cnt_r == STRAP_CAPT_CYC) && !wr_cfg |=> $stable(mode_r))
        else $error("mode moved without write"); // [R17]
    AST_NARROW2: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (st_r == ST_IDLE) && frm_evt && (mode_r == MODE_NARROW) |=> stg_cnt_r == 2'h2)
        else $error("narrow frame not two pixels"); // [R5]
    AST_LOW1: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (st_r == ST_IDLE) && frm_evt && (mode_r == MODE_WIDE_LOW) |=> stg_cnt_r == 2'h1)
        else $error("wide low frame not one pixel"); // [R4]
    AST_PERR: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        frm_evt && ^frm |=> perr_r) else $error("parity error missed"); // [R1]
endmodule

`default_nettype wire

// file: test/ddm_cam_model.sv
// camera serializer model: sends frames on either link, watches the reverse channel
// assumes the bench chooses frame contents and parity
`timescale 1ns/10ps
`default_nettype none

module ddm_cam_model
    import ddm_pkg::*;
(
    // forward links
    output logic [1:0]            lnk_clk_o,
    output logic [1:0][FRM_W-1:0] lnk_frame_o,
    // reverse channel
    input  wire logic [1:0]       bc_en_i,
    input  wire logic [1:0]       bc_data_i
);
    int bc_seen = 0;

    initial
    begin
        lnk_clk_o = 2'b00;
        lnk_frame_o = '0;
    end

    // control bits arrive while video runs
    always @(bc_data_i)
        if (bc_en_i != 2'b00)
            bc_seen <= bc_seen + 1;

    // one 28-bit frame per link rise
    task automatic send(input int p, input logic [FRM_W-1:0] f);
        #1;
        lnk_frame_o[p] = f;
        #2.3;
        lnk_clk_o[p] = 1'b1;
        #80;
        lnk_clk_o[p] = 1'b0;
        // stale lines show the inverse
        lnk_frame_o[p] = ~f;
        #76.7;
    endtask
endmodule

`default_nettype wire

// file: test/ddm_mode_mux_tb.sv
// self-checking bench of the mode control and input mux
// assumes the camera model on both links
`timescale 1ns/10ps
`default_nettype none

module ddm_mode_mux_tb
    import ddm_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, sel = 1'b0, wr = 1'b0, ctl = 1'b0, rdy = 1'b0;
    logic hold = 1'b0, ign = 1'b0, ph = 1'b0, pop_d = 1'b0, ctl_rx, pvalid, pclk;
    logic [2:0] strap = 3'h1;
    logic [1:0] md = 2'h0, sy = 2'h0, bc_en, bc_data, lclk;
    logic [6:0] carry;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, v;
    logic [1:0][FRM_W-1:0] lfrm;
    logic [31:0] seed = 32'h6735;
    logic [13:0] expq[$];
    ddm_pix_t pix;
    int fail_count = 0, cmp_count = 0, ap = 0, k = 0, i, j;

    ddm_mode_mux i_ddm_mode_mux (
        .sys_clk_i(clk), .rst_n_i(rst_n), .lnk_clk_i(lclk), .lnk_frame_i(lfrm),
        .sel_pin_i(sel), .strap_code_i(strap), .reg_wr_i(wr), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_rdata_o(rdata), .ctl_tx_i(ctl), .ctl_rx_o(ctl_rx),
        .bc_en_o(bc_en), .bc_data_o(bc_data), .pix_o(pix), .pix_valid_o(pvalid),
        .pix_ready_i(rdy), .pclk_o(pclk));

    ddm_cam_model i_ddm_cam_model (
        .lnk_clk_o(lclk), .lnk_frame_o(lfrm), .bc_en_i(bc_en), .bc_data_i(bc_data));

    initial
    begin
        forever #4 clk = ~clk;
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [1:0] smode(input logic [2:0] c);
        return (c[1:0] == 2'b00) ? 2'b00 : c[1:0] - 2'b01;
    endfunction

    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR %s expected %0h seen %0h", n, exp, got);
        end
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic wrr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        @(posedge clk);
        #1 v = rdata;
    endtask

    task automatic do_reset(input logic [2:0] s);
        @(posedge clk);
        strap <= s;
        rst_n <= 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        expq.delete();
        ph = 1'b0;
    endtask

    task automatic expect_frame(input logic [FRM_W-1:0] f);
        if (md == MODE_NARROW)
        begin
            expq.push_back({f[11:10], 2'b00, f[9:0]});
            expq.push_back({f[23:22], 2'b00, f[21:12]});
        end
        else if (md == MODE_WIDE_HIGH && !ph)
        begin
            expq.push_back(f[13:0]);
            carry = f[20:14];
            ph = 1'b1;
        end
        else if (md == MODE_WIDE_HIGH)
        begin
            expq.push_back({f[6:0], carry});
            expq.push_back(f[20:7]);
            ph = 1'b0;
        end
        else
            expq.push_back(f[13:0]);
    endtask

    task automatic send(input int p, input logic bad);
        logic [31:0] r;
        logic [FRM_W-1:0] f;
        r = xs();
        f = r[FRM_W-1:0];
        if (k % 5 == 0)
            sy = r[31:30];
        k++;
        f[11:10] = sy;
        f[23:22] = sy;
        f[FRM_PAR_BIT] = ^f[FRM_W-2:0] ^ bad;
        if (p == ap && !bad)
            expect_frame(f);
        i_ddm_cam_model.send(p, f);
        if (p == ap && !bad)
            chk("ctl_rx", ctl_rx, f[FRM_CTL_BIT]);
    endtask

    task automatic drain();
        for (int n = 0; n < 300 && (expq.size() > 0 || pvalid !== 1'b0); n++)
            @(posedge clk);
        chk("left", expq.size(), 0);
    endtask

    always @(posedge clk)
    begin
        if (rst_n)
        begin
            chk("bc_data", bc_data, bc_en & {2{ctl}});
            chk("pclk", pclk, pop_d);
            if (pvalid & rdy & !ign)
                chk("pixel", pix, expq.size() > 0 ? expq.pop_front() : 32'hFFFFFFFF);
        end
        pop_d <= rst_n & pvalid & rdy;
        rdy <= !hold && xs() % 4 != 0;
        ctl <= xs() % 2 == 1;
    end

    initial
    begin
        #400000;
        fail_count++;
        summarize();
    end

    initial
    begin
        for (i = 0; i < 8; i++)
        begin
            do_reset(i[2:0]);
            rd(REG_PORT_CFG);
            chk("cfg", v, {5'h0, i[2], smode(i[2:0])});
            rd(REG_STATUS);
            chk("status", v, {1'b0, i[2:0], 1'b0, i[1:0] == 2'b00, 2'b00});
            rd(REG_SEL_CTRL);
            chk("sel_ctrl", v, CTRL_RST);
            rd(8'h55);
            chk("unmapped", v, 8'h00);
            chk("bc_en", bc_en, 2'b01);
        end
        $display("test strap done");
        for (i = 0; i < 4; i++)
        begin
            md = i[1:0];
            wrr(REG_PORT_CFG, {5'h0, i[0], i[1:0]});
            rd(REG_PORT_CFG);
            chk("cfg_wr", v, {5'h0, i[0], i[1:0]});
            for (j = 0; j < 6; j++)
                send(0, 1'b0);
            drain();
        end
        $display("test modes done");
        md = MODE_NARROW;
        wrr(REG_PORT_CFG, 8'h02);
        hold <= 1'b1;
        repeat (4) send(0, 1'b0);
        chk("full", pvalid, 1'b1);
        chk("stand", pix, expq[0]);
        hold <= 1'b0;
        drain();
        $display("test fifo done");
        send(1, 1'b0);
        drain();
        sel <= 1'b1;
        ap = 1;
        repeat (5) @(posedge clk);
        chk("bc_en_pin", bc_en, 2'b10);
        rd(REG_STATUS);
        chk("active", v[STS_PORT_BIT], 1'b1);
        send(1, 1'b0);
        send(0, 1'b0);
        drain();
        wrr(REG_SEL_CTRL, 8'h01);
        ap = 0;
        rd(REG_SEL_CTRL);
        chk("bc_off", bc_en, 2'b00);
        wrr(REG_SEL_CTRL, 8'h05);
        rd(REG_SEL_CTRL);
        chk("bc_on", bc_en, 2'b01);
        send(0, 1'b0);
        send(1, 1'b0);
        drain();
        $display("test select done");
        ign <= 1'b1;
        send(0, 1'b1);
        repeat (20) @(posedge clk);
        ign <= 1'b0;
        rd(REG_STATUS);
        chk("perr", v[STS_PERR_BIT], 1'b1);
        wrr(REG_STATUS, 8'h02);
        rd(REG_STATUS);
        chk("perr_clr", v[STS_PERR_BIT], 1'b0);
        chk("bc_seen", i_ddm_cam_model.bc_seen > 0, 1'b1);
        $display("test parity done");
        summarize();
    end
endmodule

`default_nettype wire
